// [tts_dc_level_word_source.sv]
/*
 * Test tone and DC source at the head of the speaker playback path.
 * Holds its own byte registers, produces one sample per sample tick
 * and, while enabled, replaces the serial audio sample.
 * Assumes the register port and the sample tick come from logic on
 * sys_clk, so no synchroniser is needed on them.
 */
`timescale 1ns/1ns

module tts_dc_level_word_source
	import tts_pkg::*;
#(
	parameter int     SAMPLE_W = 24,        // Output sample width.
	parameter longint CLK_HZ   = TTS_CLK_HZ // Rate of sys_clk.
) (
	// Clock and reset.
	input  wire logic                sys_clk,
	input  wire logic                rstn,
	// Register port from the control interface.
	input  wire logic                regWrEn,
	input  wire logic                regRdEn,
	input  wire logic [15:0]         regAddr,
	input  wire logic [7:0]          regWrData,
	output logic [7:0]               regRdData_q,
	// Sample stream from the serial audio interface.
	input  wire logic                sampleTick,
	input  wire logic [SAMPLE_W-1:0] pcmSample,
	// Sample stream into the speaker path.
	output logic [SAMPLE_W-1:0]      ampSample_q,
	output logic                     ampValid_q,
	output logic                     toneActive_q
);

	// ****************************************************************
	// Elaboration checks and derived constants.
	// ****************************************************************
	// The sine table and DC levels are built for 24-bit samples.
	if (SAMPLE_W != 24) begin : gBadWidth
		$error("tts_dc_level_word_source serves only 24-bit samples");
	end
	if (CLK_HZ < 4 * TTS_TONE_HZ) begin : gBadClk
		$error("tts_dc_level_word_source needs a clock well above the tone");
	end

	// Phase added every sys_clk so that one period lasts 1 ms.
	localparam longint PHASE_INC_L = (TTS_TONE_HZ << TTS_PHASE_W) / CLK_HZ;
	localparam logic [TTS_PHASE_W-1:0] PHASE_INC = PHASE_INC_L[TTS_PHASE_W-1:0];

	// ****************************************************************
	// Registers.
	// ****************************************************************
	logic [7:0]              shape_q;      // Amplitude and selector.
	logic [7:0]              dcHigh_q;     // DC word bits 23 to 16.
	logic [7:0]              dcMid_q;      // DC word bits 15 to 8.
	logic [7:0]              dcLow_q;      // DC word bits 7 to 0.
	logic                    genEnable_q;  // Generator enable.
	logic [TTS_PHASE_W-1:0]  timePhase_q;  // Free-running 1 kHz phase.
	logic [6:0]              ratePhase_q;  // Phase of the fs-derived tones.
	logic [SAMPLE_W-1:0]     genSample_d;  // Generator output this tick.
	logic [SAMPLE_W-1:0]     sineSample;   // Scaled sine from the table.
	logic [6:0]              sineStep;     // Phase step fed to the table.
	logic [15:0]             sineGain;     // Gain for the amplitude code.
	logic [14:0]             timeStepWide; // Time phase scaled to steps.
	logic [23:0]             dcLevelWord;  // Assembled DC word.

	tts_sel_t sel;
	tts_amp_t amp;
	assign sel         = tts_sel_t'(shape_q[TTS_SEL_MSB:TTS_SEL_LSB]);
	assign amp         = tts_amp_t'(shape_q[TTS_AMP_MSB:TTS_AMP_LSB]);
	assign dcLevelWord = {dcHigh_q, dcMid_q, dcLow_q};

	// Register writes; reserved bits are not stored so they read zero.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			shape_q     <= TTS_RST_SHAPE;
			dcHigh_q    <= TTS_RST_DC;
			dcMid_q     <= TTS_RST_DC;
			dcLow_q     <= TTS_RST_DC;
			genEnable_q <= TTS_RST_ENABLE[TTS_EN_BIT];
		end else if (regWrEn) begin
			unique case (regAddr)
				TTS_ADDR_SHAPE:   shape_q     <= regWrData & TTS_SHAPE_MASK;
				TTS_ADDR_DC_HIGH: dcHigh_q    <= regWrData;
				TTS_ADDR_DC_MID:  dcMid_q     <= regWrData;
				TTS_ADDR_DC_LOW:  dcLow_q     <= regWrData;
				TTS_ADDR_ENABLE:  genEnable_q <= regWrData[TTS_EN_BIT];
				default: ;
			endcase
		end
	end

	// Read data is captured one edge after the read strobe and held
	// until the next read; unmapped offsets answer zero.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			regRdData_q <= 8'h00;
		end else if (regRdEn) begin
			unique case (regAddr)
				TTS_ADDR_SHAPE:   regRdData_q <= shape_q;
				TTS_ADDR_DC_HIGH: regRdData_q <= dcHigh_q;
				TTS_ADDR_DC_MID:  regRdData_q <= dcMid_q;
				TTS_ADDR_DC_LOW:  regRdData_q <= dcLow_q;
				TTS_ADDR_ENABLE:  regRdData_q <= {7'h00, genEnable_q} & TTS_ENABLE_MASK;
				default:          regRdData_q <= 8'h00;
			endcase
		end
	end

	// ****************************************************************
	// Phase generation.
	// ****************************************************************
	// The 1 kHz phase runs on wall time, so whatever the sample rate,
	// sampling it at each tick yields a 1 kHz tone. The trade-off is a
	// small frequency error from truncating the step.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			timePhase_q <= '0;
		end else begin
			timePhase_q <= timePhase_q + PHASE_INC;
		end
	end

	// The fs-derived tones step once per sample, so they follow the
	// active rate by construction. A quarter of a period per sample
	// gives fs/4, a sixth gives fs/6.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ratePhase_q <= '0;
		end else if (sampleTick) begin
			if (sel == TTS_SEL_TONE_S) begin
				ratePhase_q <= stepWrap(ratePhase_q, TTS_STEP_SIXTH_FS);
			end else begin
				ratePhase_q <= stepWrap(ratePhase_q, TTS_STEP_QUARTER_FS);
			end
		end
	end

	// Advance a step index and wrap it at one period.
	function automatic logic [6:0] stepWrap(input logic [6:0] cur, input logic [6:0] inc);
		logic [7:0] sum;
		sum = {1'b0, cur} + {1'b0, inc};
		if (sum >= 8'(TTS_STEPS_PER_CYCLE)) begin
			sum = sum - 8'(TTS_STEPS_PER_CYCLE);
		end
		return sum[6:0];
	endfunction

	// ****************************************************************
	// Sample selection.
	// ****************************************************************
	// Map the top byte of the time phase onto the table period.
	assign timeStepWide = 15'(timePhase_q[TTS_PHASE_W-1 -: 8] * 7'(TTS_STEPS_PER_CYCLE));

	// Table phase and amplitude gain.
	always_comb begin
		sineStep = (sel == TTS_SEL_TONE_1K) ? timeStepWide[14:8] : ratePhase_q;
		unique case (amp)
			TTS_AMP_M6DB:   sineGain = TTS_GAIN_M6DB;
			TTS_AMP_M4P8DB: sineGain = TTS_GAIN_M4P8DB;
			TTS_AMP_0DB:    sineGain = TTS_GAIN_0DB;
			TTS_AMP_RSVD:   sineGain = TTS_GAIN_ZERO;
		endcase
	end

	tts_sine_rom uSine (
		.phaseStep (sineStep),
		.gainQ15   (sineGain),
		.sampleOut (sineSample)
	);

	// Constant outputs bypass the gain entirely; reserved selector
	// codes output silence rather than an undefined level.
	always_comb begin
		unique case (shape_q[TTS_SEL_MSB:TTS_SEL_LSB])
			TTS_SEL_DC_WORD: genSample_d = dcLevelWord;
			TTS_SEL_DC_ZERO: genSample_d = TTS_DC_ZERO;
			TTS_SEL_DC_POS:  genSample_d = TTS_DC_HALF_POS;
			TTS_SEL_DC_NEG:  genSample_d = TTS_DC_HALF_NEG;
			TTS_SEL_TONE_1K,
			TTS_SEL_TONE_Q,
			TTS_SEL_TONE_S:  genSample_d = sineSample;
			default:         genSample_d = TTS_DC_ZERO;
		endcase
	end

	// One sample leaves per tick; while enabled the generator takes
	// the place of the serial audio sample.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ampSample_q <= '0;
			ampValid_q  <= 1'b0;
		end else begin
			ampValid_q <= sampleTick;
			if (sampleTick) begin
				ampSample_q <= genEnable_q ? genSample_d : pcmSample;
			end
		end
	end

	// Status flag showing which source feeds the speaker path.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			toneActive_q <= 1'b0;
		end else begin
			toneActive_q <= genEnable_q;
		end
	end

endmodule

// [tts_pkg.sv]
/*
 * Shared constants for the test tone and DC source: register offsets,
 * field positions, reset values, selector codes, amplitude gains and
 * the timing figures that set the 1 kHz phase step.
 * Assumes it is compiled before every module of the block.
 */
package tts_pkg;

	// ****************************************************************
	// Register map, byte wide registers on the internal control port.
	// ****************************************************************
	localparam logic [15:0] TTS_ADDR_SHAPE   = 16'h2083; // Tone shape and DC select.
	localparam logic [15:0] TTS_ADDR_DC_HIGH = 16'h2084; // DC word bits 23 to 16.
	localparam logic [15:0] TTS_ADDR_DC_MID  = 16'h2085; // DC word bits 15 to 8.
	localparam logic [15:0] TTS_ADDR_DC_LOW  = 16'h2086; // DC word bits 7 to 0.
	localparam logic [15:0] TTS_ADDR_ENABLE  = 16'h208F; // Generator enable.

	// Reset values.
	localparam logic [7:0] TTS_RST_SHAPE  = 8'h04; // Amplitude code 0, 1 kHz tone.
	localparam logic [7:0] TTS_RST_DC     = 8'h00; // Each DC byte clears.
	localparam logic [7:0] TTS_RST_ENABLE = 8'h00; // Generator off.

	// Field positions inside the shape and enable registers.
	localparam int TTS_SEL_LSB = 0;
	localparam int TTS_SEL_MSB = 3;
	localparam int TTS_AMP_LSB = 4;
	localparam int TTS_AMP_MSB = 5;
	localparam int TTS_EN_BIT  = 0;
	localparam logic [7:0] TTS_SHAPE_MASK  = 8'h3F; // Bits 7 and 6 read as zero.
	localparam logic [7:0] TTS_ENABLE_MASK = 8'h01; // Bits 7 to 1 read as zero.

	// Output selector codes.
	typedef enum logic [3:0] {
		TTS_SEL_DC_WORD = 4'h0,
		TTS_SEL_DC_ZERO = 4'h1,
		TTS_SEL_DC_POS  = 4'h2,
		TTS_SEL_DC_NEG  = 4'h3,
		TTS_SEL_TONE_1K = 4'h4,
		TTS_SEL_TONE_Q  = 4'h5,
		TTS_SEL_TONE_S  = 4'h6
	} tts_sel_t;

	// Amplitude codes and their gains in Q1.15.
	typedef enum logic [1:0] {
		TTS_AMP_M6DB   = 2'h0,
		TTS_AMP_M4P8DB = 2'h1,
		TTS_AMP_0DB    = 2'h2,
		TTS_AMP_RSVD   = 2'h3
	} tts_amp_t;
	localparam logic [15:0] TTS_GAIN_M6DB   = 16'h4027; // 0.5012 of full scale.
	localparam logic [15:0] TTS_GAIN_M4P8DB = 16'h49A8; // 0.5754 of full scale.
	localparam logic [15:0] TTS_GAIN_0DB    = 16'h7FFF; // Full scale.
	localparam logic [15:0] TTS_GAIN_ZERO   = 16'h0000; // Reserved code mutes.

	// Constant levels on the 24-bit output.
	localparam logic [23:0] TTS_DC_ZERO     = 24'h000000;
	localparam logic [23:0] TTS_DC_HALF_POS = 24'h400000;
	localparam logic [23:0] TTS_DC_HALF_NEG = 24'hC00000;

	// Sine table: one period is this many steps.
	localparam int          TTS_STEPS_PER_CYCLE = 96;
	localparam int          TTS_STEPS_PER_QUAD  = 24;
	localparam logic [6:0]  TTS_STEP_QUARTER_FS = 7'h18; // Period of 4 samples.
	localparam logic [6:0]  TTS_STEP_SIXTH_FS   = 7'h10; // Period of 6 samples.

	// Timing of the fixed 1 kHz tone.
	localparam longint TTS_CLK_HZ  = 25000000;
	localparam longint TTS_TONE_HZ = 1000;
	localparam int     TTS_PHASE_W = 32;

endpackage

// [tts_sine_rom.sv]
/*
 * Scaled sine lookup: maps a phase step of one period to a signed
 * 24-bit sample at the chosen amplitude.
 * Assumes the phase step lies below the steps of one period; larger
 * steps are folded into the last quadrant.
 */
`timescale 1ns/1ns
module tts_sine_rom
	import tts_pkg::*;
(
	// Phase and amplitude.
	input  wire logic [6:0]  phaseStep,
	input  wire logic [15:0] gainQ15,
	// Scaled sample.
	output logic [23:0]      sampleOut
);

	// ****************************************************************
	// Quadrant folding.
	// ****************************************************************
	logic [4:0]         quarterIdx; // Position inside the first quadrant.
	logic               negHalf;    // Second half of the period.
	logic signed [16:0] sineS;      // Signed full-scale sine.
	logic signed [32:0] product;    // Sine times gain.
	logic [15:0]        quarterVal; // Magnitude from the table.

	// Quadrant boundaries in table steps.
	localparam logic [6:0] STEP_QUAD  = 7'(TTS_STEPS_PER_QUAD);     // End of first quadrant.
	localparam logic [6:0] STEP_HALF  = 7'(2 * TTS_STEPS_PER_QUAD); // End of positive half.
	localparam logic [6:0] STEP_THREE = 7'(3 * TTS_STEPS_PER_QUAD); // End of third quadrant.
	localparam logic [6:0] STEP_FULL  = 7'(TTS_STEPS_PER_CYCLE);    // One whole period.

	// Fold the period onto a quarter wave to keep the table small.
	always_comb begin
		if (phaseStep < STEP_QUAD) begin
			quarterIdx = phaseStep[4:0];
			negHalf    = 1'b0;
		end else if (phaseStep < STEP_HALF) begin
			quarterIdx = 5'(STEP_HALF - phaseStep);
			negHalf    = 1'b0;
		end else if (phaseStep < STEP_THREE) begin
			quarterIdx = 5'(phaseStep - STEP_HALF);
			negHalf    = 1'b1;
		end else begin
			quarterIdx = 5'(STEP_FULL - phaseStep);
			negHalf    = 1'b1;
		end
	end

	// Quarter wave in steps of 3.75 degrees.
	always_comb begin
		unique case (quarterIdx)
			5'd0:    quarterVal = 16'h0000;
			5'd1:    quarterVal = 16'h085F;
			5'd2:    quarterVal = 16'h10B5;
			5'd3:    quarterVal = 16'h18F9;
			5'd4:    quarterVal = 16'h2121;
			5'd5:    quarterVal = 16'h2925;
			5'd6:    quarterVal = 16'h30FB;
			5'd7:    quarterVal = 16'h389D;
			5'd8:    quarterVal = 16'h4000;
			5'd9:    quarterVal = 16'h471C;
			5'd10:   quarterVal = 16'h4DEB;
			5'd11:   quarterVal = 16'h5465;
			5'd12:   quarterVal = 16'h5A82;
			5'd13:   quarterVal = 16'h603C;
			5'd14:   quarterVal = 16'h658C;
			5'd15:   quarterVal = 16'h6A6D;
			5'd16:   quarterVal = 16'h6EDA;
			5'd17:   quarterVal = 16'h72CB;
			5'd18:   quarterVal = 16'h7641;
			5'd19:   quarterVal = 16'h7934;
			5'd20:   quarterVal = 16'h7BA3;
			5'd21:   quarterVal = 16'h7D8A;
			5'd22:   quarterVal = 16'h7EE7;
			5'd23:   quarterVal = 16'h7FB9;
			default: quarterVal = 16'h7FFF; // Peak; codes above 24 cannot occur.
		endcase
	end

	// Apply sign and amplitude; the product peaks just under 2^30,
	// so bits 30 to 7 hold the 24-bit result without overflow.
	always_comb begin
		sineS     = negHalf ? -$signed({1'b0, quarterVal}) : $signed({1'b0, quarterVal});
		product   = sineS * $signed({1'b0, gainQ15});
		sampleOut = product[30:7];
	end

endmodule

// [tts_chk_asserts.sv]
/*
 * Port checker for the tone and DC source.
 * Assumes it is bound to tts_dc_level_word_source with a 24-bit sample.
 */
`timescale 1ns/1ns
module tts_chk_asserts
	import tts_pkg::*;
(
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Register port.
	input  wire logic        regWrEn,
	input  wire logic        regRdEn,
	input  wire logic [15:0] regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic [7:0]  regRdData_q,
	// Sample streams.
	input  wire logic        sampleTick,
	input  wire logic [23:0] pcmSample,
	input  wire logic [23:0] ampSample_q,
	input  wire logic        ampValid_q,
	input  wire logic        toneActive_q
);
	logic [7:0]  shp_q, hi_q, mid_q, lo_q, en_q; // Mirrors of the registers.
	logic [7:0]  rdExp;                          // Expected read data.
	logic [23:0] dcExp;                          // Expected constant level.

	// Mirrors follow the writes so the checks see what the host asked for.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			{shp_q, hi_q, mid_q, lo_q, en_q} <= {TTS_RST_SHAPE, 32'h0};
		end else if (regWrEn) begin
			case (regAddr)
				TTS_ADDR_SHAPE:   shp_q <= regWrData & TTS_SHAPE_MASK;
				TTS_ADDR_DC_HIGH: hi_q <= regWrData;
				TTS_ADDR_DC_MID:  mid_q <= regWrData;
				TTS_ADDR_DC_LOW:  lo_q <= regWrData;
				TTS_ADDR_ENABLE:  en_q <= regWrData & TTS_ENABLE_MASK;
				default:          ;
			endcase
		end
	end

	// Unmapped addresses read as zero.
	always_comb begin
		case (regAddr)
			TTS_ADDR_SHAPE:   rdExp = shp_q;
			TTS_ADDR_DC_HIGH: rdExp = hi_q;
			TTS_ADDR_DC_MID:  rdExp = mid_q;
			TTS_ADDR_DC_LOW:  rdExp = lo_q;
			TTS_ADDR_ENABLE:  rdExp = en_q;
			default:          rdExp = 8'h00;
		endcase
		case (shp_q[3:0])
			4'h0:    dcExp = {hi_q, mid_q, lo_q};
			4'h1:    dcExp = TTS_DC_ZERO;
			4'h2:    dcExp = TTS_DC_HALF_POS;
			4'h3:    dcExp = TTS_DC_HALF_NEG;
			default: dcExp = 24'h000000;
		endcase
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// A tick taken while the generator is off.
	sequence offTick;
		(sampleTick && !toneActive_q) ##1 !toneActive_q;
	endsequence

	a_valid_after_tick: assert property (sampleTick |=> ampValid_q) else $error("no valid");
	a_no_extra_valid: assert property (!sampleTick |=> !ampValid_q) else $error("extra");
	a_sample_stands: assert property (!sampleTick |=> $stable(ampSample_q)) else $error("moved");
	a_pcm_passes: assert property (offTick |-> ampSample_q == $past(pcmSample))
		else $error("pcm not passed");
	a_dc_levels: assert property (sampleTick && en_q[0] && !(shp_q[3:0] inside {[4'h4:4'h6]})
		|=> ampSample_q == $past(dcExp)) else $error("bad level");
	a_read_value: assert property (regRdEn |=> regRdData_q == $past(rdExp)) else $error("rd");
	a_read_holds: assert property (!regRdEn |=> $stable(regRdData_q)) else $error("rd moved");
	a_active_delay: assert property (toneActive_q == $past(en_q[0])) else $error("active");
endmodule

bind tts_dc_level_word_source tts_chk_asserts u_chk (.sys_clk, .rstn, .regWrEn, .regRdEn, .regAddr,
	.regWrData, .regRdData_q, .sampleTick, .pcmSample, .ampSample_q, .ampValid_q, .toneActive_q);

// [tts_spk_model.sv]
/*
 * Speaker path sink: counts the samples it is handed.
 * Assumes the valid pulse is one cycle per sample on sys_clk.
 */
`timescale 1ns/1ns
module tts_spk_model (
	// Clock and reset.
	input  wire logic sys_clk,
	input  wire logic rstn,
	// Incoming stream.
	input  wire logic ampValid_q,
	// Samples seen.
	output int        rxCount
);
	// One count per valid pulse.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rxCount <= 0;
		end else if (ampValid_q) begin
			rxCount <= rxCount + 1;
		end
	end
endmodule

// [test_test_dc_level_word_source.sv]
/*
 * Self-checking bench for the tone and DC source.
 * Assumes the package, design, checker and sink model are compiled first.
 */
`timescale 1ns/1ns
module test_test_dc_level_word_source;
	import tts_pkg::*;
	logic        sys_clk, rstn, regWrEn, regRdEn, sampleTick;
	logic [15:0] regAddr;
	logic [7:0]  regWrData, regRdData_q;
	logic [23:0] pcmSample, ampSample_q;
	logic        ampValid_q, toneActive_q;
	int          rxCount, errorCnt, checkCount, sent;
	logic [24:0] expQ [$];  // Notes; bit 24 set means record only.
	logic [23:0] hist [$];  // Every sample seen.
	localparam logic [24:0] TONE = 25'h1000000;
	logic [15:0] ad [6] = '{TTS_ADDR_SHAPE, TTS_ADDR_DC_HIGH, TTS_ADDR_DC_MID, TTS_ADDR_DC_LOW,
		TTS_ADDR_ENABLE, 16'h2087};
	logic [7:0]  rv [6] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  fv [6] = '{8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h00};

	tts_dc_level_word_source uut (.sys_clk(sys_clk), .rstn(rstn), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData_q(regRdData_q), .sampleTick(sampleTick), .pcmSample(pcmSample),
		.ampSample_q(ampSample_q), .ampValid_q(ampValid_q), .toneActive_q(toneActive_q));
	tts_spk_model spk (.sys_clk(sys_clk), .rstn(rstn), .ampValid_q(ampValid_q),
		.rxCount(rxCount));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
		checkCount++;
		if (got !== exp) begin
			errorCnt++;
			$display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask

	task automatic endSim;
		$display("checks %0d mismatches %0d", checkCount, errorCnt);
		if (errorCnt == 0 && checkCount > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Tasks start and end just after a rising edge. Each strobe is
	// followed by at least one idle edge, so that two calls in a row never
	// lower and raise the same strobe in one time step.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		{regWrEn, regAddr, regWrData} = {1'b1, a, d};
		@(posedge sys_clk) #1;
		regWrEn = 1'b0;
		@(posedge sys_clk) #1;
	endtask

	// Read data is registered at the strobe's edge and holds, so it
	// is compared just after that edge.
	task automatic rd(input logic [15:0] a, input logic [7:0] d);
		{regRdEn, regAddr} = {1'b1, a};
		@(posedge sys_clk) #1;
		regRdEn = 1'b0;
		chk(regRdData_q, d, "read");
		@(posedge sys_clk) #1;
	endtask

	task automatic tick(input int gap, input logic [24:0] e, input logic [23:0] p);
		{sampleTick, pcmSample} = {1'b1, p};
		expQ.push_back(e);
		@(posedge sys_clk) #1;
		sampleTick = 1'b0;
		sent++;
		repeat (gap) @(posedge sys_clk) #1;
	endtask

	// Monitor: each valid sample takes the oldest note. It looks at
	// the falling edge, where the registered outputs have settled.
	always @(negedge sys_clk) begin
		logic [24:0] e;
		if (ampValid_q === 1'b1) begin
			hist.push_back(ampSample_q);
			if (expQ.size() == 0) chk(24'h0, 24'h1, "sample without note");
			else begin
				e = expQ.pop_front();
				if (!e[24]) chk(ampSample_q, e[23:0], "sample");
			end
		end
	end

	initial begin
		repeat (100000) @(posedge sys_clk);
		errorCnt++;
		endSim();
	end

	initial begin
		logic [31:0] w;
		logic [23:0] ex;
		int pk [4];
		int v, n;
		{rstn, regWrEn, regRdEn, sampleTick, regAddr, regWrData, pcmSample} = '0;
		void'($urandom(57599));
		repeat (2) @(posedge sys_clk) #1;
		rstn = 1'b1;
		for (int i = 0; i < 6; i++) rd(ad[i], rv[i]);
		for (int i = 0; i < 6; i++) wr(ad[i], 8'hFF);
		for (int i = 0; i < 6; i++) rd(ad[i], fv[i]);
		wr(TTS_ADDR_ENABLE, 8'h00);
		for (int i = 0; i < 3; i++) begin
			ex = 24'($urandom());
			tick(1, {1'b0, ex}, ex);
		end
		$display("test registers and pass-through done");
		w = $urandom() | 32'h800000;
		wr(TTS_ADDR_DC_HIGH, w[23:16]);
		wr(TTS_ADDR_DC_MID, w[15:8]);
		wr(TTS_ADDR_DC_LOW, w[7:0]);
		wr(TTS_ADDR_ENABLE, 8'h01);
		for (int a = 0; a < 4; a++) for (int s = 0; s < 6; s++) begin
			ex = (s == 0) ? w[23:0] : (s == 2) ? TTS_DC_HALF_POS : (s == 3) ? TTS_DC_HALF_NEG : 0;
			wr(TTS_ADDR_SHAPE, {2'b00, a[1:0], (s > 3) ? 4'(s + 3 + s * s) : s[3:0]});
			tick(1, {1'b0, ex}, 24'($urandom()));
		end
		chk(toneActive_q, 1'b1, "active");
		$display("test dc levels done");
		for (int a = 0; a < 4; a++) begin
			wr(TTS_ADDR_SHAPE, {2'b00, a[1:0], 4'h5});
			hist.delete();
			for (int i = 0; i < 12; i++) tick(1 + $urandom_range(3), TONE, 24'($urandom()));
			for (int i = 0; i < 8; i++) chk(hist[i], hist[i + 4], "quarter period");
			pk[a] = 0;
			foreach (hist[i]) begin
				v = $signed(hist[i]);
				if (v < 0) v = -v;
				if (v > pk[a]) pk[a] = v;
			end
		end
		chk({23'h0, pk[2] > pk[1] && pk[1] > pk[0] && pk[0] > 0}, 24'h1, "amplitude");
		chk(pk[3][23:0], 24'h0, "reserved amplitude");
		wr(TTS_ADDR_SHAPE, 8'h26);
		hist.delete();
		for (int i = 0; i < 12; i++) tick(1 + $urandom_range(3), TONE, 24'h0);
		for (int i = 0; i < 6; i++) chk(hist[i], hist[i + 6], "sixth period");
		chk({23'h0, hist[1] != hist[4] || hist[2] != hist[5]}, 24'h1, "sixth moves");
		wr(TTS_ADDR_SHAPE, 8'h24);
		hist.delete();
		for (int i = 0; i < 1500; i++) tick(24, TONE, 24'h0);
		n = 0;
		for (int i = 1; i < 1500; i++) if (hist[i - 1][23] && !hist[i][23]) n++;
		chk({23'h0, n inside {1, 2}}, 24'h1, "1 kHz crossings");
		$display("test tones done");
		wr(TTS_ADDR_ENABLE, 8'h00);
		ex = 24'($urandom());
		tick(1, {1'b0, ex}, ex);
		chk(toneActive_q, 1'b0, "inactive");
		chk(rxCount[23:0], sent[23:0], "sample count");
		$display("test disable and count done");
		endSim();
	end
endmodule
